// ---- common/rst_seq_pkg.sv ----
// Constants and types shared by the reset pin sequencer.
// Assumes a 25 MHz bus clock and an APB register port with 8-bit byte addresses.
package rst_seq_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CLEAR  = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_CTRL   = 8'h0c;
  localparam logic [7:0] OFF_OPT    = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int CTRL_SWRST_BIT     = 0;
  localparam int CTRL_GPIO_MODE_BIT = 1;
  localparam int CTRL_GPIO_OUT_BIT  = 2;
  localparam int OPT_PIN_CFG_BIT    = 0;
  localparam int EV_W               = 5;

  // ==========================================================================
  // Reset values
  localparam logic [EV_W-1:0] ENABLE_RST  = 5'h00;
  localparam logic [1:0]      CTRL_RST    = 2'h0;
  localparam logic            PIN_EN_RST  = 1'b1;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ        = 25000;
  localparam int MIN_ASSERT_CYC = 128;
  localparam int PULSE_MAX_US   = 24;
  localparam int PULSE_MAX_CYC  = (PULSE_MAX_US * CLK_KHZ) / 1000;
  localparam int CNT_W          = 10;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic wake;
    logic pulse_long;
    logic int_src;
    logic sw_req;
    logic pin;
  } rst_events_t;

  typedef enum logic [1:0] {
    ST_POR,
    ST_ASSERT,
    ST_RELEASE,
    ST_RUN
  } seq_state_t;

endpackage

// ---- logic/pin_level_sync.sv ----
// Three-flop synchroniser with agreement filter for an asynchronous pin.
// Assumes the pin idles high through its pull-up.
`timescale 1ns/1ns
module pin_level_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_async,
  output logic      pin_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // ==========================================================================
  // Synchroniser chain and agreement filter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r <= pin_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign pin_level = level_r;

endmodule // pin_level_sync

// ---- logic/reset_pin_sequencer.sv ----
// Reset pin sequencer with APB status and control registers.
// Assumes flash, option and supply readiness inputs are on the bus clock domain.
`timescale 1ns/1ns

module reset_pin_sequencer #(
  parameter int NUM_SRC = 4
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               reset_pin_in,
  output logic                    reset_pin_out,
  output logic                    reset_pin_oe,
  input  wire logic               regulator_ready,
  input  wire logic               ref_clk_ready,
  input  wire logic               option_valid,
  input  wire logic [7:0]         flash_option_word,
  input  wire logic               flash_init_done,
  input  wire logic [NUM_SRC-1:0] int_reset_src,
  input  wire logic               low_power_mode,
  output logic                    chip_reset_n,
  output logic                    wakeup,
  output logic                    irq
);

  rst_seq_pkg::seq_state_t  state_r;
  rst_seq_pkg::rst_events_t status_r;
  rst_seq_pkg::rst_events_t events;
  logic [rst_seq_pkg::EV_W-1:0] enable_r;
  logic [rst_seq_pkg::CNT_W-1:0] cnt_r;
  logic [1:0]  ctrl_r;
  logic        sw_req_r;
  logic        pin_en_r;
  logic        chip_reset_n_r;
  logic        wakeup_r;
  logic [31:0] prdata_r;
  logic        pin_hi;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        pin_trig;
  logic        int_trig;
  logic        go_run;
  logic        min_done;
  logic        pod_low;

  // ==========================================================================
  // Pin input synchroniser.
  pin_level_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (reset_pin_in),
    .pin_level (pin_hi)
  );

  // ==========================================================================
  // Sequencer.
  assign pin_trig = (state_r == rst_seq_pkg::ST_RUN) && pin_en_r && !pin_hi;
  assign int_trig = (state_r == rst_seq_pkg::ST_RUN) && (sw_req_r || (|int_reset_src));
  assign min_done = cnt_r >= rst_seq_pkg::CNT_W'(rst_seq_pkg::MIN_ASSERT_CYC - 1);
  assign go_run   = ((state_r == rst_seq_pkg::ST_RELEASE) && (!pin_en_r || pin_hi))
                 || ((state_r == rst_seq_pkg::ST_RUN) && !pin_trig && !int_trig);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rst_seq_pkg::ST_POR;
    end else begin
      case (state_r)
        rst_seq_pkg::ST_POR: begin
          if (regulator_ready && ref_clk_ready && option_valid) begin
            state_r <= rst_seq_pkg::ST_ASSERT;
          end
        end
        rst_seq_pkg::ST_ASSERT: begin
          if (min_done && flash_init_done) begin
            state_r <= rst_seq_pkg::ST_RELEASE;
          end
        end
        rst_seq_pkg::ST_RELEASE: begin
          if (go_run) begin
            state_r <= rst_seq_pkg::ST_RUN;
          end
        end
        default: begin
          if (pin_trig || int_trig) begin
            state_r <= rst_seq_pkg::ST_ASSERT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (state_r != rst_seq_pkg::ST_ASSERT) begin
      cnt_r <= '0;
    end else if (cnt_r != rst_seq_pkg::CNT_W'(rst_seq_pkg::PULSE_MAX_CYC)) begin
      cnt_r <= cnt_r + rst_seq_pkg::CNT_W'(1);
    end
  end

  // Chip reset follows go_run by one clock, so with the pin enabled it also waits for the synchronised pin to read high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_reset_n_r <= 1'b0;
    end else begin
      chip_reset_n_r <= go_run;
    end
  end

  // Option is captured in every power-on cycle with option_valid set and held after power-on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_en_r <= rst_seq_pkg::PIN_EN_RST;
    end else if ((state_r == rst_seq_pkg::ST_POR) && option_valid) begin
      pin_en_r <= flash_option_word[rst_seq_pkg::OPT_PIN_CFG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_r <= 1'b0;
    end else begin
      wakeup_r <= low_power_mode && pin_en_r && !pin_hi;
    end
  end

  // ==========================================================================
  // Pin drive.
  assign pod_low = !pin_en_r && ctrl_r[0] && !ctrl_r[1]
                && (state_r == rst_seq_pkg::ST_RUN);
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = (state_r == rst_seq_pkg::ST_POR)
                      || (state_r == rst_seq_pkg::ST_ASSERT) || pod_low;
  assign chip_reset_n  = chip_reset_n_r;
  assign wakeup        = wakeup_r;

  // ==========================================================================
  // Events and interrupt.
  always_comb begin
    events            = '0;
    events.pin        = pin_trig;
    events.sw_req     = int_trig && sw_req_r;
    events.int_src    = int_trig && (|int_reset_src);
    events.pulse_long = (state_r == rst_seq_pkg::ST_ASSERT)
                     && (cnt_r == rst_seq_pkg::CNT_W'(rst_seq_pkg::PULSE_MAX_CYC - 1));
    events.wake       = low_power_mode && pin_en_r && !pin_hi;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else if (wr_en && (paddr == rst_seq_pkg::OFF_CLEAR)) begin
      status_r <= (status_r & ~pwdata[rst_seq_pkg::EV_W-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  assign irq = |(status_r & enable_r);

  // ==========================================================================
  // APB slave.
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr == rst_seq_pkg::OFF_STATUS) || (paddr == rst_seq_pkg::OFF_CLEAR)
                || (paddr == rst_seq_pkg::OFF_ENABLE) || (paddr == rst_seq_pkg::OFF_CTRL)
                || (paddr == rst_seq_pkg::OFF_OPT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= rst_seq_pkg::ENABLE_RST;
      ctrl_r   <= rst_seq_pkg::CTRL_RST;
      sw_req_r <= 1'b0;
    end else begin
      sw_req_r <= 1'b0;
      if (wr_en && (paddr == rst_seq_pkg::OFF_ENABLE)) begin
        enable_r <= pwdata[rst_seq_pkg::EV_W-1:0];
      end else if (wr_en && (paddr == rst_seq_pkg::OFF_CTRL)) begin
        sw_req_r <= pwdata[rst_seq_pkg::CTRL_SWRST_BIT];
        ctrl_r   <= {pwdata[rst_seq_pkg::CTRL_GPIO_OUT_BIT],
                     pwdata[rst_seq_pkg::CTRL_GPIO_MODE_BIT]};
      end
    end
  end

  // Read data is loaded in the setup cycle and stands during the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (rd_en) begin
      if (paddr == rst_seq_pkg::OFF_STATUS) begin
        prdata_r <= {27'h0, status_r};
      end else if (paddr == rst_seq_pkg::OFF_ENABLE) begin
        prdata_r <= {27'h0, enable_r};
      end else if (paddr == rst_seq_pkg::OFF_CTRL) begin
        prdata_r <= {29'h0, ctrl_r[1], ctrl_r[0], 1'b0};
      end else if (paddr == rst_seq_pkg::OFF_OPT) begin
        prdata_r <= {29'h0, chip_reset_n_r, pin_hi, pin_en_r};
      end else begin
        prdata_r <= 32'h0;
      end
    end
  end

  // ==========================================================================
  // Assertions.
  sequence s_release;
    !reset_pin_oe ##1 chip_reset_n;
  endsequence

  AST_MIN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rst_seq_pkg::ST_ASSERT) && (cnt_r < 10'h07f) |=> reset_pin_oe)
    else $error("Reset pin released before the minimum low time.");

  AST_FLASH_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(state_r == rst_seq_pkg::ST_ASSERT) |-> $past(flash_init_done) && $past(min_done))
    else $error("Reset pin released before flash initialisation ended.");

  AST_REL_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(chip_reset_n) |-> $past(!reset_pin_oe))
    else $error("Chip reset deasserted while the pin was still driven.");

  AST_RUN_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rst_seq_pkg::ST_RELEASE) && go_run |-> s_release)
    else $error("Release did not lead to chip reset deassertion.");

  AST_EXT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    pin_en_r && !pin_hi |=> !chip_reset_n)
    else $error("Chip reset deasserted while the pin was held low.");

  AST_OD_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    reset_pin_oe && (state_r == rst_seq_pkg::ST_RUN) |-> !pin_en_r && !reset_pin_out)
    else $error("Pin driven in run state while the reset function is enabled.");

  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_mode && pin_en_r && !pin_hi |=> wakeup)
    else $error("Low pin did not wake the device.");

  AST_PIN_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    pin_trig |=> status_r.pin && (state_r == rst_seq_pkg::ST_ASSERT))
    else $error("Pin reset did not set the pin reset flag.");

  AST_OPT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    state_r != rst_seq_pkg::ST_POR |=> $stable(pin_en_r))
    else $error("Option setting changed outside power-on.");

  AST_POR_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == rst_seq_pkg::ST_POR |-> reset_pin_oe)
    else $error("Pin not driven low before the option was loaded.");

  AST_NO_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_en_r |=> !wakeup)
    else $error("Disabled pin caused a wake-up.");

  AST_PULSE_LONG: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rst_seq_pkg::ST_ASSERT) && (cnt_r == 10'h257) |=> status_r.pulse_long)
    else $error("Overlong reset pulse not flagged.");

  AST_START: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rst_seq_pkg::ST_POR) && !(regulator_ready && ref_clk_ready)
    |=> state_r == rst_seq_pkg::ST_POR)
    else $error("Sequencing started without regulator or reference clock.");

  AST_INT_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    int_trig |=> reset_pin_oe && !chip_reset_n)
    else $error("Internal reset did not drive the pin low.");

  AST_PIN_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rst_seq_pkg::ST_RUN) && !pin_en_r && !int_trig
    |=> state_r == rst_seq_pkg::ST_RUN)
    else $error("Disabled reset pin started a reset.");

  AST_POD_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rst_seq_pkg::ST_RUN) && !pin_en_r && ctrl_r[0] && !ctrl_r[1]
    |-> reset_pin_oe)
    else $error("Pseudo open-drain output did not drive low.");

endmodule // reset_pin_sequencer

// ---- tb/reset_line_board.sv ----
// Board side of the reset line: pull-up, push-button and the device's open-drain driver.
// Assumes the device drives only low and the button pulls the line to ground.
`timescale 1ns/1ns
// ========
// Line resolution
module reset_line_board (
  input  wire logic dev_oe,
  input  wire logic dev_out,
  input  wire logic button_press,
  input  wire logic dbg_erase_req,
  output logic      dbg_mass_erase,
  output logic      dbg_sys_reset_req,
  output logic      line_level
);
  // A debugger mass erase with the pin disabled sets both request fields together.
  assign dbg_mass_erase    = dbg_erase_req;
  assign dbg_sys_reset_req = dbg_erase_req;
  // Any party pulling low wins, otherwise the pull-up gives a high level.
  assign line_level = ((dev_oe && !dev_out) || button_press) ? 1'b0 : 1'b1;
endmodule // reset_line_board

// ---- tb/tb_reset_pin_sequencer.sv ----
// Self-checking bench for the reset pin sequencer.
// Assumes the board model resolves the reset line and the APB port answers at once.
`timescale 1ns/1ns
module tb_reset_pin_sequencer;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, fopt;
  logic [31:0] pwdata, prdata, rd;
  logic        pin_in, pin_out, pin_oe, btn, reg_rdy, clk_rdy, opt_ok;
  logic        fdone, lpm, crn, wakeup, irq;
  logic [3:0]  src;
  logic        dbg_req, dbg_me, dbg_sr;
  int          n_errors = 0, compares = 0, cyc = 0, n;

  // ========
  // Design and board
  reset_pin_sequencer #(.NUM_SRC(4)) i_reset_pin_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .regulator_ready(reg_rdy), .ref_clk_ready(clk_rdy), .option_valid(opt_ok),
    .flash_option_word(fopt), .flash_init_done(fdone),
    .int_reset_src(src | {dbg_me & dbg_sr, 3'h0}),
    .low_power_mode(lpm), .chip_reset_n(crn), .wakeup(wakeup), .irq(irq));
  reset_line_board i_reset_line_board (
    .dev_oe(pin_oe), .dev_out(pin_out), .button_press(btn), .dbg_erase_req(dbg_req),
    .dbg_mass_erase(dbg_me), .dbg_sys_reset_req(dbg_sr), .line_level(pin_in));

  // ========
  // Clock and timeout
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("[FAIL] %0t timeout", $time);
      n_errors++;
      summarize();
    end
  end

  // ========
  // Helpers
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts pin-drive cycles until the chip reset is released again.
  task automatic watch();
    n = 0;
    for (int k = 0; k < 3000; k++) begin
      @(negedge pclk);
      n += int'(pin_oe);
      if (k > 8 && crn === 1'b1) break;
    end
  endtask

  // ========
  // Scenarios
  task automatic t_por();
    wait_n(10);
    chk({31'h0, pin_oe}, 32'h1, "oe before regulator");
    @(posedge pclk);
    reg_rdy <= 1'b1;
    clk_rdy <= 1'b0;
    wait_n(10);
    chk({31'h0, pin_oe}, 32'h1, "oe before reference clock");
    @(posedge pclk);
    clk_rdy <= 1'b1;
    opt_ok <= 1'b0;
    wait_n(10);
    chk({31'h0, pin_oe}, 32'h1, "oe before option");
    @(posedge pclk);
    opt_ok <= 1'b1;
    wait_n(300);
    chk({31'h0, pin_oe}, 32'h1, "oe while flash busy");
    @(posedge pclk);
    fdone <= 1'b1;
    watch();
    chk({31'h0, crn}, 32'h1, "chip reset release");
    chk({31'h0, pin_oe}, 32'h0, "pin released first");
    apb(1'b0, rst_seq_pkg::OFF_ENABLE, 32'h0);
    chk(rd, 32'h0, "enable reset value");
  endtask
  task automatic t_src();
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      src <= 4'h1 << i;
      @(posedge pclk);
      src <= 4'h0;
      watch();
      chk({31'h0, n >= rst_seq_pkg::MIN_ASSERT_CYC}, 32'h1, "short pulse");
      chk({31'h0, n <= rst_seq_pkg::PULSE_MAX_CYC}, 32'h1, "long pulse");
    end
    @(posedge pclk);
    fdone <= 1'b0;
    src <= 4'h1;
    @(posedge pclk);
    src <= 4'h0;
    wait_n(rst_seq_pkg::PULSE_MAX_CYC + 10);
    @(posedge pclk);
    fdone <= 1'b1;
    watch();
    apb(1'b0, rst_seq_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0000000c, "overlong pulse flagged");
  endtask
  task automatic t_pin();
    @(posedge pclk);
    btn <= 1'b1;
    wait_n(400);
    chk({31'h0, crn}, 32'h0, "held by pin");
    chk({30'h0, pin_out, pin_oe}, 32'h0, "drive low only");
    @(posedge pclk);
    btn <= 1'b0;
    watch();
    chk({31'h0, crn}, 32'h1, "after pin release");
    apb(1'b0, rst_seq_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "pin flag");
    apb(1'b1, rst_seq_pkg::OFF_ENABLE, 32'h1);
    wait_n(1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, rst_seq_pkg::OFF_CLEAR, 32'h1);
    apb(1'b0, rst_seq_pkg::OFF_STATUS, 32'h0);
    chk({30'h0, rd[0], irq}, 32'h0, "flag cleared");
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
  endtask
  task automatic t_wake();
    @(posedge pclk);
    lpm <= 1'b1;
    btn <= 1'b1;
    wait_n(8);
    chk({31'h0, wakeup}, 32'h1, "pin wake");
    @(posedge pclk);
    btn <= 1'b0;
    lpm <= 1'b0;
    watch();
    apb(1'b0, rst_seq_pkg::OFF_STATUS, 32'h0);
    chk({30'h0, rd[4], rd[0]}, 32'h3, "wake flag");
  endtask
  task automatic t_off();
    @(posedge pclk);
    presetn <= 1'b0;
    fopt <= 8'h00;
    @(posedge pclk);
    presetn <= 1'b1;
    watch();
    apb(1'b0, rst_seq_pkg::OFF_OPT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0, "pin disabled");
    @(posedge pclk);
    lpm <= 1'b1;
    btn <= 1'b1;
    wait_n(20);
    chk({31'h0, crn}, 32'h1, "pin ignored");
    chk({31'h0, wakeup}, 32'h0, "no wake");
    @(posedge pclk);
    btn <= 1'b0;
    lpm <= 1'b0;
    apb(1'b1, rst_seq_pkg::OFF_CTRL, 32'h1);
    watch();
    apb(1'b0, rst_seq_pkg::OFF_OPT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0, "option kept");
    apb(1'b0, rst_seq_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h2, "software reset only");
    @(posedge pclk);
    dbg_req <= 1'b1;
    @(posedge pclk);
    dbg_req <= 1'b0;
    watch();
    chk({31'h0, n >= rst_seq_pkg::MIN_ASSERT_CYC}, 32'h1, "debug erase reset");
    apb(1'b1, rst_seq_pkg::OFF_CTRL, 32'h2);
    wait_n(2);
    chk({31'h0, pin_oe}, 32'h1, "gpio low");
    apb(1'b1, rst_seq_pkg::OFF_CTRL, 32'h6);
    wait_n(2);
    chk({31'h0, pin_oe}, 32'h0, "gpio high");
  endtask

  // ========
  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, btn, reg_rdy, fdone, lpm, dbg_req} = 8'h00;
    {clk_rdy, opt_ok} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    fopt = 8'h01;
    src = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_src();
    t_pin();
    t_wake();
    t_off();
    summarize();
  end
endmodule // tb_reset_pin_sequencer
